/* common/act_defines.svh */
// Register offsets, field positions, reset values and timing counts for the timing block
`ifndef ACT_DEFINES_SVH
`define ACT_DEFINES_SVH

`define ACT_OFS_TIMING      12'h000
`define ACT_OFS_TRIG        12'h004
`define ACT_OFS_STATUS      12'h008

`define ACT_SRC_BIT         15
`define ACT_SAMPLE_HI       12
`define ACT_SAMPLE_LO       8
`define ACT_DIV_HI          7
`define ACT_DIV_LO          0
`define ACT_TIMING_MASK     16'h9fff
`define ACT_TIMING_RST      16'h0000
`define ACT_TRIG_RST        3'h0
`define ACT_TRIG_AUTO       3'h7
`define ACT_DIV_MAX         8'h3f

`endif

/* common/act_pkg.sv */
// Types shared by the converter timing block
package act_pkg;

	typedef struct packed {
		logic        conv_clock_source_select;
		logic [4:0]  auto_sample_duration;
		logic [7:0]  conv_clock_divider;
	} act_timing_t;

	typedef enum logic [1:0] {
		ACT_IDLE   = 2'b00,
		ACT_SAMPLE = 2'b01,
		ACT_DONE   = 2'b11
	} act_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} act_apb_req_t;

endpackage

/* hdl/act_tick_div.sv */
// Programmable divider making the conversion-clock tick from the instruction cycle, or passing the RC tick through when use_rc is set
`timescale 1ns/1ns
`include "act_defines.svh"

module act_tick_div #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Control
	input  wire logic             cyc_en,
	input  wire logic             rc_tick,
	input  wire logic             use_rc,
	input  wire logic [DIV_W-1:0] divider,
	// Tick out
	output logic                  tick
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} act_div_state_t;

	act_div_state_t s_q;
	act_div_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (use_rc) begin
			s_d.cnt  = '0;
			s_d.tick = rc_tick;                       // [RULE_01] [RULE_04]
		end else if (cyc_en) begin
			if (s_q.cnt >= divider) begin
				s_d.cnt  = '0;
				s_d.tick = 1'b1;                      // [RULE_03] [RULE_06]
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule

/* hdl/act_sample_timer.sv */
// Counts the auto-sample interval in conversion-clock ticks
`timescale 1ns/1ns

module act_sample_timer #(
	parameter int CNT_W = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Control
	input  wire logic             start,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] duration,
	// Status
	output logic                  busy,
	output logic                  done
);

	typedef struct packed {
		act_pkg::act_state_t st;
		logic [CNT_W-1:0]    cnt;
	} act_tmr_state_t;

	act_tmr_state_t s_q;
	act_tmr_state_t s_d;

	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			act_pkg::ACT_IDLE: begin
				if (start) begin
					s_d.cnt = duration;
					s_d.st  = (duration == '0) ? act_pkg::ACT_DONE : act_pkg::ACT_SAMPLE;
				end
			end
			act_pkg::ACT_SAMPLE: begin
				if (tick) begin
					if (s_q.cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						s_d.st = act_pkg::ACT_DONE;           // [RULE_02] [RULE_06]
					end
					s_d.cnt = s_q.cnt - 1'b1;
				end
			end
			act_pkg::ACT_DONE: begin
				s_d.st = act_pkg::ACT_IDLE;
			end
			default: begin
				s_d.st = act_pkg::ACT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{st: act_pkg::ACT_IDLE, cnt: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = (s_q.st == act_pkg::ACT_SAMPLE);
	assign done = (s_q.st == act_pkg::ACT_DONE);

endmodule

/* hdl/act_timing_top.sv */
// Converter clock-source, divider and auto-sample timing control with APB registers
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "act_defines.svh"

//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01: Source bit one selects internal RC clock, zero derives from system clock.
// RULE_02: Five-bit sample field gives sample time of 0 to 31 conversion periods.
// RULE_03: Divider sets conversion period to cycle period times field plus one; 64+ reserved.
// RULE_04: Divider field is ignored while the internal RC clock is selected.
// RULE_05: Sample duration only acts when the trigger source equals 111.
// RULE_06: A tick each time the cycle counter reaches divider; sampling counts ticks.
module act_timing_top #(
	parameter int DIV_W = 8,
	parameter int SMP_W = 5
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Converter side
	input  wire logic        cyc_en,
	input  wire logic        rc_tick,
	input  wire logic        sample_start,
	output logic             conv_tick,
	output logic             auto_convert,
	output logic             sampling
);

	//////////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		act_pkg::act_timing_t timing;
		logic [2:0]           conversion_trigger_source;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 conv_tick;
		logic                 auto_convert;
		logic                 sampling;
		logic                 reserved_div;
	} act_top_state_t;

	act_top_state_t    s_q;
	act_top_state_t    s_d;
	act_pkg::act_apb_req_t req;

	// Reset value of the 16-bit register, split into the packed fields
	localparam logic [15:0]          TIMING_RST_W = `ACT_TIMING_RST;
	localparam act_pkg::act_timing_t TIMING_RST   = '{
		conv_clock_source_select: TIMING_RST_W[`ACT_SRC_BIT],
		auto_sample_duration:     TIMING_RST_W[`ACT_SAMPLE_HI:`ACT_SAMPLE_LO],
		conv_clock_divider:       TIMING_RST_W[`ACT_DIV_HI:`ACT_DIV_LO]
	};

	logic              tick;
	logic              tmr_busy;
	logic              tmr_done;
	logic              auto_mode;
	logic              tmr_start;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
		pwdata: pwdata};

	function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	//////////////////////////////////////////////////////////////////////////////////////
	// Conversion clock and sample timer

	act_tick_div #(
		.DIV_W   (DIV_W)
	) u_div (
		.clk     (clk),
		.reset_n (reset_n),
		.cyc_en  (cyc_en),
		.rc_tick (rc_tick),
		.use_rc  (s_q.timing.conv_clock_source_select),   // [RULE_01]
		.divider (s_q.timing.conv_clock_divider),
		.tick    (tick)
	);

	assign auto_mode = (s_q.conversion_trigger_source == `ACT_TRIG_AUTO);
	assign tmr_start = sample_start & auto_mode;               // [RULE_05]

	act_sample_timer #(
		.CNT_W    (SMP_W)
	) u_tmr (
		.clk      (clk),
		.reset_n  (reset_n),
		.start    (tmr_start),
		.tick     (tick),
		.duration (s_q.timing.auto_sample_duration),       // [RULE_02]
		.busy     (tmr_busy),
		.done     (tmr_done)
	);

	//////////////////////////////////////////////////////////////////////////////////////
	// Register access and outputs

	always_comb begin
		logic access;
		logic [15:0] w16;
		access         = req.psel & req.penable;
		w16            = req.pwdata[15:0];
		s_d            = s_q;
		s_d.pready     = 1'b0;
		s_d.pslverr    = 1'b0;
		s_d.conv_tick  = tick;
		s_d.sampling   = tmr_busy;
		s_d.auto_convert = tmr_done & auto_mode;               // [RULE_05]
		if (req.psel && !req.penable) begin
			s_d.pready = 1'b1;
			s_d.prdata = '0;
			if (is_addr(req.paddr, `ACT_OFS_TIMING)) begin
				s_d.prdata[15:0] = {s_q.timing.conv_clock_source_select, 2'b00,
					s_q.timing.auto_sample_duration, s_q.timing.conv_clock_divider};
			end else if (is_addr(req.paddr, `ACT_OFS_TRIG)) begin
				s_d.prdata[2:0] = s_q.conversion_trigger_source;
			end else if (is_addr(req.paddr, `ACT_OFS_STATUS)) begin
				s_d.prdata[2:0] = {s_q.reserved_div, tmr_done, tmr_busy};
			end else begin
				s_d.pslverr = 1'b1;
			end
		end
		if (access && req.pwrite && s_q.pready) begin
			if (is_addr(req.paddr, `ACT_OFS_TIMING)) begin
				s_d.timing.conv_clock_source_select = w16[`ACT_SRC_BIT];
				s_d.timing.auto_sample_duration = w16[`ACT_SAMPLE_HI:`ACT_SAMPLE_LO];
				s_d.timing.conv_clock_divider = w16[`ACT_DIV_HI:`ACT_DIV_LO];
				s_d.reserved_div = (w16[`ACT_DIV_HI:`ACT_DIV_LO] > `ACT_DIV_MAX); // [RULE_03]
			end else if (is_addr(req.paddr, `ACT_OFS_TRIG)) begin
				s_d.conversion_trigger_source = req.pwdata[2:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.timing <= TIMING_RST;
			s_q.conversion_trigger_source <= `ACT_TRIG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata       = s_q.prdata;
	assign pready       = s_q.pready;
	assign pslverr      = s_q.pslverr;
	assign conv_tick    = s_q.conv_tick;
	assign auto_convert = s_q.auto_convert;
	assign sampling     = s_q.sampling;

endmodule

/* test/act_timing_sva.sv */
// Port checker for the converter timing block
`timescale 1ns/1ns
module act_timing_sva (
	// Clock
	input wire logic        clk,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Converter
	input wire logic        cyc_en,
	input wire logic        rc_tick,
	input wire logic        sample_start,
	input wire logic        conv_tick,
	input wire logic        auto_convert,
	input wire logic        sampling
);
	logic       src_q;
	logic [4:0] dur_q;
	logic [2:0] trig_q;
	wire        wr = psel && penable && pready && pwrite;
	// Copies of the settings as committed over the bus
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			src_q <= 1'b0;
			dur_q <= 5'h00;
			trig_q <= 3'h0;
		end else if (wr && paddr == 12'h000) begin
			src_q <= pwdata[15];
			dur_q <= pwdata[12:8];
		end else if (wr && paddr == 12'h004) begin
			trig_q <= pwdata[2:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	//////////////////////////////////////////////////////////////////////////////
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("late ready");
	property p_err; pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}); endproperty
	a_err: assert property (p_err) else $error("bad error flag");
	property p_rc_src; src_q && rc_tick |-> ##2 conv_tick; endproperty
	a_rc_src: assert property (p_rc_src) else $error("rc tick lost");
	property p_rc_only; conv_tick && $past(src_q, 2) |-> $past(rc_tick, 2); endproperty
	a_rc_only: assert property (p_rc_only) else $error("divider used in rc mode");
	property p_sys_only; conv_tick && !$past(src_q, 2) |-> $past(cyc_en, 2); endproperty
	a_sys_only: assert property (p_sys_only) else $error("tick without cycle");
	property p_zero; sample_start && trig_q == 3'h7 && dur_q == 5'h00 |=> !sampling ##1 auto_convert;
	endproperty
	a_zero: assert property (p_zero) else $error("zero sample wrong");
	property p_rise; sample_start && trig_q == 3'h7 && dur_q != 5'h00 |=> ##1 sampling; endproperty
	a_rise: assert property (p_rise) else $error("sampling not started");
	property p_off; sample_start && trig_q != 3'h7 |=> (!sampling && !auto_convert) [*3]; endproperty
	a_off: assert property (p_off) else $error("sampling outside auto");
endmodule

bind act_timing_top act_timing_sva u_sva (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .cyc_en, .rc_tick, .sample_start, .conv_tick, .auto_convert, .sampling);

/* test/act_timing_top_bench.sv */
// Self-checking bench for the converter timing block
`timescale 1ns/1ns
module act_timing_top_bench;
	logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        cyc_en = 1'b0, rc_tick = 1'b0, sample_start = 1'b0, run = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, conv_tick, auto_convert, sampling, err, a, s;
	logic [2:0]  ph = 3'h0;
	logic [7:0]  dv [4] = '{8'h00, 8'h02, 8'h3f, 8'h40};
	int          bad_count = 0, num_checks = 0, cyc = 0, n;
	act_timing_top dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cyc_en, .rc_tick, .sample_start, .conv_tick, .auto_convert, .sampling);
	//////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic tk;
		do @(posedge clk); while (conv_tick !== 1'b1);
	endtask
	task automatic smp(input logic [4:0] t, input logic x);
		apb(1'b1, 12'h000, {19'h0, t, 8'h03});
		tk();
		tk();
		sample_start <= 1'b1;
		@(posedge clk) sample_start <= 1'b0;
		n = 0;
		s = 1'b0;
		repeat (300) begin
			@(posedge clk);
			s |= sampling;
			n += conv_tick;
			a = auto_convert;
			if (a === 1'b1) break;
		end
		check("auto", a, x);
		check("sampling", s, x && t != 5'h00);
		if (x) check("ticks", n, t);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;
	// Cycle enable every second clock, internal RC tick every eighth
	always @(posedge clk) begin
		ph <= ph + 3'h1;
		cyc_en <= run & ~cyc_en;
		rc_tick <= ph == 3'h2;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		run <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 12; i += 4) begin
			apb(1'b0, 12'(i), 32'h0);
			check("reset", rd, 32'h0);
		end
		apb(1'b1, 12'h000, 32'hffffffff);
		apb(1'b0, 12'h000, 32'h0);
		check("timing", rd, 32'h9fff);
		apb(1'b0, 12'h00c, 32'h0);
		check("unmapped", {rd[30:0], err}, 32'h1);
		foreach (dv[i]) begin
			apb(1'b1, 12'h000, {24'h0, dv[i]});
			tk();
			tk();
			n = 0;
			do begin
				@(posedge clk);
				n += cyc_en;
			end while (conv_tick !== 1'b1);
			check("period", n, 32'(dv[i]) + 1);
		end
		apb(1'b0, 12'h008, 32'h0);
		check("reserved", rd[2], 1'b1);
		apb(1'b1, 12'h000, 32'h8005);
		n = 0;
		repeat (64) begin
			@(posedge clk);
			n += conv_tick;
		end
		check("rc", n, 8);
		apb(1'b1, 12'h004, 32'h3);
		apb(1'b0, 12'h004, 32'h0);
		check("trigger", rd, 32'h3);
		smp(5'h04, 1'b0);
		apb(1'b1, 12'h004, 32'h7);
		smp(5'h00, 1'b1);
		smp(5'h01, 1'b1);
		smp(5'h1f, 1'b1);
		results();
	end
endmodule
